//--- core/txwp_map.svh
// layout, depth and timing constants of the transmit write port
`ifndef TXWP_MAP_SVH
`define TXWP_MAP_SVH

// ----------------------------------------------------------------------------
// partition layout
// ----------------------------------------------------------------------------
`define TXWP_NUM_PART      8
`define TXWP_PART_W        3
`define TXWP_IDX_W         4
`define TXWP_PTR_W         5
`define TXWP_LINE_ADDR_W   7
`define TXWP_LINES         128
`define TXWP_PTR_ONE       5'h01
`define TXWP_DEPTH_32      5'h04
`define TXWP_CAP_64        5'h08
`define TXWP_CAP_128       5'h10

// ----------------------------------------------------------------------------
// word widths
// ----------------------------------------------------------------------------
`define TXWP_HALF_W        64
`define TXWP_LINE_W        128
`define TXWP_PORT_W        8
`define TXWP_STAT_W        2
`define TXWP_BURST_W       4
`define TXWP_BURST_ONE     4'h1
`define TXWP_REF_DIV_W     2
`define TXWP_REF_DIV_ONE   2'h1
`define TXWP_REF_BIT       1

`endif

//--- core/txwp_pkg.sv
// types and pointer helpers of the transmit write port
`include "txwp_map.svh"

package txwp_pkg;

    typedef logic [`TXWP_PTR_W-1:0]  txwp_ptr_t;
    typedef logic [`TXWP_PART_W-1:0] txwp_part_t;

    // ------------------------------------------------------------------------
    // one buffer line with its sideband
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`TXWP_LINE_W-1:0] data;
        logic [`TXWP_PORT_W-1:0] port;
        logic                    sop;
        logic                    eop;
        logic                    err;
    } txwp_line_t;

    typedef enum logic {
        TXWP_AG_IDLE,
        TXWP_AG_BURST
    } txwp_ag_state_t;

    function automatic txwp_ptr_t txwp_bin2gray(input txwp_ptr_t b);
        return b ^ (b >> 1);
    endfunction : txwp_bin2gray

    function automatic txwp_ptr_t txwp_gray2bin(input txwp_ptr_t g);
        txwp_ptr_t b;
        b[`TXWP_PTR_W-1] = g[`TXWP_PTR_W-1];
        for (int i = `TXWP_PTR_W-2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : txwp_gray2bin

endpackage : txwp_pkg

//--- core/txwp_sync.sv
// two-flop synchroniser for levels and gray-coded pointer vectors
module txwp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    import txwp_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } txwp_sync_state_t;

    txwp_sync_state_t s;
    txwp_sync_state_t next_s;

    // meta is read only by the second stage
    always_comb begin
        next_s        = s;
        next_s.meta   = i_async;
        next_s.stable = s.meta;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.stable;

endmodule : txwp_sync

//--- core/txwp_agent.sv
// polling agent: picks a partition and grants it a burst of line reads
module txwp_agent (
    input  wire logic                     i_link_clk,
    input  wire logic                     i_reset,
    input  wire logic [`TXWP_NUM_PART-1:0] i_nonempty,
    input  wire logic [`TXWP_NUM_PART-1:0] i_poll_disable,
    input  wire logic [`TXWP_BURST_W-1:0] i_max_burst,
    input  wire logic                     i_line_eop,
    output logic                          o_read,
    output txwp_pkg::txwp_part_t          o_read_part,
    output logic [`TXWP_BURST_W-1:0]      o_grant_len
);
    import txwp_pkg::*;

    typedef struct packed {
        txwp_ag_state_t           state;
        txwp_part_t               part;
        txwp_part_t               last;
        logic [`TXWP_BURST_W-1:0] left;
        logic [`TXWP_BURST_W-1:0] len;
    } txwp_ag_t;

    txwp_ag_t s;
    txwp_ag_t next_s;

    always_comb begin
        txwp_part_t cand;
        logic       found;
        cand   = '0;
        found  = 1'b0;
        next_s = s;
        o_read = 1'b0;
        case (s.state)
            TXWP_AG_IDLE: begin
                // round robin from the partition after the last one served
                for (int k = 1; k <= `TXWP_NUM_PART; k++) begin
                    cand = txwp_part_t'(s.last + txwp_part_t'(k));
                    if (!found && i_nonempty[cand] && !i_poll_disable[cand]) begin
                        found        = 1'b1;
                        next_s.part  = cand;
                    end
                end
                if (found) begin
                    next_s.state = TXWP_AG_BURST;
                    // zero burst would stall the port, serve one line instead
                    next_s.left  = (i_max_burst == '0) ? `TXWP_BURST_ONE : i_max_burst;
                    next_s.len   = next_s.left;
                end
            end
            TXWP_AG_BURST: begin
                o_read = i_nonempty[s.part] && !i_poll_disable[s.part];
                if (!o_read || s.left == `TXWP_BURST_ONE || i_line_eop) begin
                    next_s.state = TXWP_AG_IDLE;
                    next_s.last  = s.part;
                end
                if (o_read) begin
                    next_s.left = s.left - `TXWP_BURST_ONE;
                end
            end
            default: begin
                next_s.state = TXWP_AG_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_link_clk or posedge i_reset) begin
        if (i_reset) begin
            s <= '{state: TXWP_AG_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign o_read_part = s.part;
    assign o_grant_len = s.len;

endmodule : txwp_agent

//--- core/txwp_port.sv
// transmit write port: partitioned packet buffer between fabric and link
//
// Notes on behaviour
// - end of packet advances partition write pointer
// - narrow mode captures 64-bit word on strobe
// - line terminate advances addressed partition pointer
// - disabled buffer is not polled until released
// - disabled buffer yields idle words on link
// - disabled partition still accepts writes until full
// - write clock independent of link clock
// - full flag for selected partition above threshold
// - serviced port number, real or substitute value
// - two-bit flow status of serviced port
// - four-bit count of cycles granted to port
// - quarter-rate reference clock for fabric logic
// - align select, synchronised, drives the status clock skewed flag
// - up to eight partitions by 3-bit select
// - wide partitions four times 32-bit depth
// - several ports may share one partition
// - wide mode: one write fills one line
module txwp_port (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    // ------------------------------------------------------------------------
    // fabric write side, on i_clk
    // ------------------------------------------------------------------------
    input  wire logic                     i_wide_mode,
    input  wire logic                     i_buffer_write_strobe,
    input  wire logic [`TXWP_HALF_W-1:0]  i_write_word_64,
    input  wire logic [`TXWP_LINE_W-1:0]  i_write_word_128,
    input  wire logic [`TXWP_PART_W-1:0]  i_partition_select,
    input  wire logic [`TXWP_PART_W-1:0]  i_wide_partition_select,
    input  wire logic [`TXWP_PORT_W-1:0]  i_write_port_tag,
    input  wire logic                     i_start_of_packet,
    input  wire logic                     i_end_of_packet,
    input  wire logic                     i_pkt_error_flag,
    input  wire logic                     i_line_write_terminate,
    input  wire logic [`TXWP_NUM_PART-1:0] i_buffer_poll_disable,
    input  wire logic [`TXWP_PTR_W-1:0]   i_fill_threshold,
    input  wire logic                     i_status_clock_align_select,
    output logic                          o_partition_full_flag,
    // ------------------------------------------------------------------------
    // link side, on i_link_clk
    // ------------------------------------------------------------------------
    input  wire logic                     i_link_clk,
    input  wire logic [`TXWP_BURST_W-1:0] i_max_burst,
    input  wire logic [`TXWP_STAT_W-1:0]  i_port_flow_status,
    input  wire logic                     i_port_substitute_en,
    input  wire logic [`TXWP_PORT_W-1:0]  i_port_substitute,
    output logic                          o_link_valid,
    output logic                          o_link_idle,
    output logic [`TXWP_LINE_W-1:0]       o_link_data,
    output logic                          o_link_sop,
    output logic                          o_link_eop,
    output logic                          o_link_err,
    output logic [`TXWP_PORT_W-1:0]       o_serviced_port_number,
    output logic [`TXWP_STAT_W-1:0]       o_serviced_port_flow_status,
    output logic [`TXWP_BURST_W-1:0]      o_service_cycle_count,
    output logic                          o_quarter_rate_ref_clock,
    output logic                          o_status_clock_skewed
);
    import txwp_pkg::*;

    // ------------------------------------------------------------------------
    // state of each domain
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                                 half_pend;
        logic [`TXWP_HALF_W-1:0]              half_data;
        logic                                 half_sop;
        logic [`TXWP_PORT_W-1:0]              half_port;
        logic [`TXWP_NUM_PART-1:0][`TXWP_PTR_W-1:0] wptr;
        logic [`TXWP_NUM_PART-1:0][`TXWP_PTR_W-1:0] wgray;
        logic                                 full;
    } txwp_wr_t;

    typedef struct packed {
        logic [`TXWP_NUM_PART-1:0][`TXWP_PTR_W-1:0] rptr;
        logic [`TXWP_NUM_PART-1:0][`TXWP_PTR_W-1:0] rgray;
        logic                                 valid;
        logic                                 idle;
        txwp_line_t                           line;
        logic [`TXWP_PORT_W-1:0]              port_num;
        logic [`TXWP_STAT_W-1:0]              flow;
        logic [`TXWP_BURST_W-1:0]             count;
        logic [`TXWP_REF_DIV_W-1:0]           ref_div;
        logic                                 skewed;
    } txwp_rd_t;

    txwp_wr_t   w;
    txwp_wr_t   next_w;
    txwp_rd_t   r;
    txwp_rd_t   next_r;

    // shared partitioned line store; written on i_clk, read on i_link_clk
    txwp_line_t mem [`TXWP_LINES];

    logic                                 mem_we;
    logic [`TXWP_LINE_ADDR_W-1:0]         mem_waddr;
    txwp_line_t                           mem_wline;

    logic [`TXWP_NUM_PART*`TXWP_PTR_W-1:0] rgray_at_wr;
    logic [`TXWP_NUM_PART*`TXWP_PTR_W-1:0] wgray_at_rd;
    logic [`TXWP_NUM_PART-1:0]             dis_at_rd;
    logic                                  align_at_rd;
    logic [`TXWP_NUM_PART-1:0]             nonempty;
    logic                                  ag_read;
    txwp_part_t                            ag_part;
    logic [`TXWP_BURST_W-1:0]              ag_len;
    txwp_line_t                            rd_line;

    // ------------------------------------------------------------------------
    // crossings: pointers travel gray coded, controls as levels
    // ------------------------------------------------------------------------
    txwp_sync #(.WIDTH(`TXWP_NUM_PART*`TXWP_PTR_W)) u_rptr_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (r.rgray),
        .o_sync  (rgray_at_wr)
    );

    txwp_sync #(.WIDTH(`TXWP_NUM_PART*`TXWP_PTR_W)) u_wptr_sync (
        .i_clk   (i_link_clk),
        .i_reset (i_reset),
        .i_async (w.wgray),
        .o_sync  (wgray_at_rd)
    );

    txwp_sync #(.WIDTH(`TXWP_NUM_PART+1)) u_ctrl_sync (
        .i_clk   (i_link_clk),
        .i_reset (i_reset),
        .i_async ({i_status_clock_align_select, i_buffer_poll_disable}),
        .o_sync  ({align_at_rd, dis_at_rd})
    );

    // ------------------------------------------------------------------------
    // write side
    // ------------------------------------------------------------------------
    function automatic txwp_ptr_t txwp_level(input txwp_ptr_t wp, input txwp_ptr_t rg);
        return txwp_ptr_t'(wp - txwp_gray2bin(rg));
    endfunction : txwp_level

    always_comb begin
        txwp_part_t p;
        txwp_ptr_t  cap;
        txwp_ptr_t  lvl;
        logic       room;
        logic       advance;
        p         = i_wide_mode ? i_wide_partition_select : i_partition_select;
        cap       = i_wide_mode ? `TXWP_CAP_128 : `TXWP_CAP_64;
        lvl       = txwp_level(w.wptr[p], rgray_at_wr[p*`TXWP_PTR_W +: `TXWP_PTR_W]);
        room      = lvl < cap;
        advance   = 1'b0;
        next_w    = w;
        mem_we    = 1'b0;
        mem_waddr = {p, w.wptr[p][`TXWP_IDX_W-1:0]};
        mem_wline = '0;
        // port tag kept per line, so ports may share a partition
        mem_wline.port = i_write_port_tag;
        if (i_buffer_write_strobe && room) begin
            if (i_wide_mode) begin
                mem_wline.data = i_write_word_128;
                mem_wline.sop  = i_start_of_packet;
                mem_wline.eop  = i_end_of_packet;
                mem_wline.err  = i_pkt_error_flag && i_end_of_packet;
                mem_we         = 1'b1;
                advance        = 1'b1;
            end else if (!w.half_pend) begin
                if (i_end_of_packet) begin
                    // packet ends on the first half: line closes early
                    mem_wline.data = {{`TXWP_HALF_W{1'b0}}, i_write_word_64};
                    mem_wline.sop  = i_start_of_packet;
                    mem_wline.eop  = 1'b1;
                    mem_wline.err  = i_pkt_error_flag;
                    mem_we         = 1'b1;
                    advance        = 1'b1;
                end else begin
                    next_w.half_pend = 1'b1;
                    next_w.half_data = i_write_word_64;
                    next_w.half_sop  = i_start_of_packet;
                    next_w.half_port = i_write_port_tag;
                end
            end else begin
                mem_wline.data   = {i_write_word_64, w.half_data};
                mem_wline.port   = w.half_port;
                mem_wline.sop    = w.half_sop;
                mem_wline.eop    = i_end_of_packet;
                mem_wline.err    = i_pkt_error_flag && i_end_of_packet;
                mem_we           = 1'b1;
                advance          = 1'b1;
                next_w.half_pend = 1'b0;
            end
        end else if (i_line_write_terminate && room) begin
            // a half line waiting is committed rather than lost
            mem_wline.data   = {{`TXWP_HALF_W{1'b0}}, w.half_data & {`TXWP_HALF_W{w.half_pend}}};
            mem_wline.port   = w.half_pend ? w.half_port : i_write_port_tag;
            mem_wline.sop    = w.half_pend && w.half_sop;
            mem_we           = 1'b1;
            advance          = 1'b1;
            next_w.half_pend = 1'b0;
        end
        if (advance) begin
            next_w.wptr[p] = txwp_ptr_t'(w.wptr[p] + `TXWP_PTR_ONE);
        end
        for (int i = 0; i < `TXWP_NUM_PART; i++) begin
            next_w.wgray[i] = txwp_bin2gray(next_w.wptr[i]);
        end
        // full follows the level each cycle, so it drops as the link drains
        next_w.full = txwp_level(next_w.wptr[p], rgray_at_wr[p*`TXWP_PTR_W +: `TXWP_PTR_W])
                      > i_fill_threshold;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            w <= '0;
        end else begin
            w <= next_w;
        end
    end

    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wline;
        end
    end

    // ------------------------------------------------------------------------
    // link side
    // ------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `TXWP_NUM_PART; i++) begin
            nonempty[i] = txwp_gray2bin(wgray_at_rd[i*`TXWP_PTR_W +: `TXWP_PTR_W]) != r.rptr[i];
        end
    end

    assign rd_line = mem[{ag_part, r.rptr[ag_part][`TXWP_IDX_W-1:0]}];

    txwp_agent u_agent (
        .i_link_clk     (i_link_clk),
        .i_reset        (i_reset),
        .i_nonempty     (nonempty),
        .i_poll_disable (dis_at_rd),
        .i_max_burst    (i_max_burst),
        .i_line_eop     (rd_line.eop),
        .o_read         (ag_read),
        .o_read_part    (ag_part),
        .o_grant_len    (ag_len)
    );

    always_comb begin
        next_r         = r;
        next_r.ref_div = r.ref_div + `TXWP_REF_DIV_ONE;
        next_r.skewed  = align_at_rd;
        next_r.valid   = ag_read;
        next_r.idle    = !ag_read;
        next_r.line    = '0;
        if (ag_read) begin
            next_r.line          = rd_line;
            next_r.rptr[ag_part] = txwp_ptr_t'(r.rptr[ag_part] + `TXWP_PTR_ONE);
            next_r.port_num      = i_port_substitute_en ? i_port_substitute
                                                        : rd_line.port;
            next_r.flow          = i_port_flow_status;
            next_r.count         = ag_len;
        end
        for (int i = 0; i < `TXWP_NUM_PART; i++) begin
            next_r.rgray[i] = txwp_bin2gray(next_r.rptr[i]);
        end
    end

    always_ff @(posedge i_link_clk or posedge i_reset) begin
        if (i_reset) begin
            r <= '{idle: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all straight from state flops
    // ------------------------------------------------------------------------
    assign o_partition_full_flag       = w.full;
    assign o_link_valid                = r.valid;
    assign o_link_idle                 = r.idle;
    assign o_link_data                 = r.line.data;
    assign o_link_sop                  = r.line.sop;
    assign o_link_eop                  = r.line.eop;
    assign o_link_err                  = r.line.err;
    assign o_serviced_port_number      = r.port_num;
    assign o_serviced_port_flow_status = r.flow;
    assign o_service_cycle_count       = r.count;
    assign o_quarter_rate_ref_clock    = r.ref_div[`TXWP_REF_BIT];
    assign o_status_clock_skewed       = r.skewed;

endmodule : txwp_port

//--- dv/txwp_props.sv
// link-side checks on the transmit write port
module txwp_props (
    input wire logic         i_reset,
    input wire logic         i_link_clk,
    input wire logic [7:0]   i_buffer_poll_disable,
    input wire logic [3:0]   i_max_burst,
    input wire logic [1:0]   i_port_flow_status,
    input wire logic         i_port_substitute_en,
    input wire logic [7:0]   i_port_substitute,
    input wire logic         i_status_clock_align_select,
    input wire logic         o_link_valid,
    input wire logic         o_link_idle,
    input wire logic [127:0] o_link_data,
    input wire logic         o_link_sop,
    input wire logic         o_link_eop,
    input wire logic         o_link_err,
    input wire logic [7:0]   o_serviced_port_number,
    input wire logic [1:0]   o_serviced_port_flow_status,
    input wire logic [3:0]   o_service_cycle_count,
    input wire logic         o_quarter_rate_ref_clock,
    input wire logic         o_status_clock_skewed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_link_clk); endclocking
    default disable iff (i_reset);
    a_idle_mirrors_valid: assert property (o_link_idle == !o_link_valid)
        else $error("idle flag disagrees with valid");
    a_idle_line_blank: assert property (!o_link_valid |-> o_link_data == 128'h0
        && !o_link_sop && !o_link_eop && !o_link_err) else $error("idle line not blank");
    // sync plus an in-flight read need a few cycles to stop
    a_disabled_silent: assert property ((&i_buffer_poll_disable) [*8] |-> !o_link_valid)
        else $error("line sent while all buffers disabled");
    a_burst_bounded: assert property (o_link_valid |-> o_service_cycle_count != 4'h0
        && o_service_cycle_count <= ((i_max_burst == 4'h0) ? 4'h1 : i_max_burst))
        else $error("burst count out of range");
    a_flow_captured: assert property (o_link_valid
        |-> o_serviced_port_flow_status == $past(i_port_flow_status)) else $error("flow status");
    a_port_substitute: assert property (o_link_valid && $past(i_port_substitute_en)
        |-> o_serviced_port_number == $past(i_port_substitute)) else $error("substitute port");
    a_ref_quarter: assert property ($rose(o_quarter_rate_ref_clock) |=> o_quarter_rate_ref_clock
        ##1 !o_quarter_rate_ref_clock [*2] ##1 o_quarter_rate_ref_clock) else $error("ref clock");
    a_skew_follows: assert property ($stable(i_status_clock_align_select) [*4]
        |-> o_status_clock_skewed == i_status_clock_align_select) else $error("skew select");
endmodule : txwp_props

bind txwp_port txwp_props u_props (.*);

//--- dv/txwp_writer.sv
// fabric writer model feeding packet lines into the write port
module txwp_writer (
    input  wire logic    i_clk,
    output logic         o_strobe,
    output logic [63:0]  o_word_64,
    output logic [127:0] o_word_128,
    output logic [2:0]   o_select,
    output logic [7:0]   o_tag,
    output logic         o_sop,
    output logic         o_eop,
    output logic         o_err,
    output logic         o_terminate
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_strobe, o_word_64, o_word_128, o_select, o_tag, o_sop, o_eop, o_err, o_terminate} = '0;
    task automatic put(input logic [2:0] p, input logic [7:0] t, input logic [127:0] d,
                       input logic s, input logic e, input logic er);
        @(negedge i_clk);
        {o_strobe, o_terminate, o_select, o_tag} = {2'b10, p, t};
        {o_word_64, o_word_128} = {d[63:0], d};
        {o_sop, o_eop, o_err} = {s, e, er & e};
    endtask : put
    // data lines flip after release so stale values never look valid
    task automatic rest();
        @(negedge i_clk);
        {o_strobe, o_terminate, o_word_64, o_word_128} = {2'b00, ~o_word_64, ~o_word_128};
    endtask : rest
    task automatic line64(input logic [2:0] p, input logic [7:0] t, input logic [63:0] lo,
                          input logic [63:0] hi);
        put(p, t, {64'h0, lo}, 1'b1, 1'b0, 1'b0);
        put(p, t, {64'h0, hi}, 1'b0, 1'b1, 1'b0);
    endtask : line64
    task automatic term(input logic [2:0] p);
        @(negedge i_clk);
        {o_strobe, o_terminate, o_select} = {2'b01, p};
    endtask : term
endmodule : txwp_writer

//--- dv/tb.sv
// self-checking bench for the transmit write port
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: %0h %0h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_clk = 1'b0, i_link_clk = 1'b0, i_reset = 1'b1, i_wide_mode = 1'b0;
    logic         i_buffer_write_strobe, i_start_of_packet, i_end_of_packet, i_pkt_error_flag;
    logic         i_line_write_terminate, i_port_substitute_en = 1'b0;
    logic         i_status_clock_align_select = 1'b0;
    logic [63:0]  i_write_word_64;
    logic [127:0] i_write_word_128, o_link_data;
    logic [2:0]   i_partition_select, i_wide_partition_select;
    logic [7:0]   i_write_port_tag, i_buffer_poll_disable = 8'hFF, i_port_substitute = 8'h5A;
    logic [7:0]   o_serviced_port_number;
    logic [4:0]   i_fill_threshold = 5'h03;
    logic [3:0]   i_max_burst = 4'h2, o_service_cycle_count;
    logic [1:0]   i_port_flow_status = 2'h1, o_serviced_port_flow_status;
    logic         o_partition_full_flag, o_link_valid, o_link_idle, o_link_sop, o_link_eop;
    logic         o_link_err, o_quarter_rate_ref_clock, o_status_clock_skewed;
    int           bad_count = 0, comparisons = 0, cyc = 0;
    assign i_wide_partition_select = i_partition_select;
    initial forever #4 i_clk = ~i_clk;
    initial begin
        #7; // link clock free of the write clock phase
        forever #24 i_link_clk = ~i_link_clk;
    end
    txwp_port uut (.*);
    txwp_writer u_wr (.i_clk(i_clk), .o_strobe(i_buffer_write_strobe),
        .o_word_64(i_write_word_64), .o_word_128(i_write_word_128), .o_select(i_partition_select),
        .o_tag(i_write_port_tag), .o_sop(i_start_of_packet), .o_eop(i_end_of_packet),
        .o_err(i_pkt_error_flag), .o_terminate(i_line_write_terminate));
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic expect_line(input logic [127:0] d, input logic [7:0] p, input logic [2:0] f);
        int n;
        n = 0;
        do begin
            @(negedge i_link_clk);
            n++;
        end while (o_link_valid !== 1'b1 && n < 200);
        `CHK(o_link_valid, 1'b1)
        `CHK(o_link_data, d)
        `CHK({o_link_sop, o_link_eop, o_link_err}, f)
        `CHK(o_serviced_port_number, p)
        `CHK(o_serviced_port_flow_status, i_port_flow_status)
    endtask : expect_line
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // several port tags share partition 2, filled past threshold while parked
    task automatic fill_drain_narrow();
        for (int k = 0; k < 8; k++) begin
            u_wr.line64(3'h2, 8'h20 + 8'(k), 64'hA0 + 64'(k), 64'hB0 + 64'(k));
            u_wr.rest();
            repeat (2) @(negedge i_clk);
            `CHK(o_partition_full_flag, (k >= 3))
            `CHK(o_link_valid, 1'b0)
        end
        i_buffer_poll_disable = 8'h00;
        for (int k = 0; k < 8; k++) begin
            expect_line({64'hB0 + 64'(k), 64'hA0 + 64'(k)}, 8'h20 + 8'(k), 3'b110);
        end
        repeat (40) @(negedge i_clk);
        `CHK(o_partition_full_flag, 1'b0)
    endtask : fill_drain_narrow
    task automatic wide_error_substitute();
        {i_wide_mode, i_port_substitute_en, i_status_clock_align_select} = 3'b111;
        i_port_flow_status = 2'h2;
        u_wr.put(3'h5, 8'h33, {64'hC1, 64'hD2}, 1'b1, 1'b1, 1'b1);
        u_wr.rest();
        expect_line({64'hC1, 64'hD2}, 8'h5A, 3'b111);
        `CHK(o_status_clock_skewed, 1'b1)
    endtask : wide_error_substitute
    // empty lines from terminate still count towards the fill level
    task automatic terminate_lines();
        @(negedge i_clk);
        {i_wide_mode, i_port_substitute_en, i_buffer_poll_disable} = {2'b00, 8'hFF};
        repeat (4) u_wr.term(3'h1);
        u_wr.rest();
        repeat (2) @(negedge i_clk);
        `CHK(o_partition_full_flag, 1'b1)
        u_wr.term(3'h2);
        u_wr.rest();
        u_wr.rest();
        `CHK(o_partition_full_flag, 1'b0)
        u_wr.o_select = 3'h1;
        repeat (2) @(negedge i_clk);
        `CHK(o_partition_full_flag, 1'b1)
        i_buffer_poll_disable = 8'h00;
        repeat (150) @(negedge i_clk);
        `CHK(o_partition_full_flag, 1'b0)
    endtask : terminate_lines
    initial begin
        repeat (2) @(posedge i_link_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        fill_drain_narrow();
        wide_error_substitute();
        terminate_lines();
        print_verdict();
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
endmodule : tb
